/* File: core/pps_consts.svh */
`ifndef PPS_CONSTS_SVH
`define PPS_CONSTS_SVH

// geometry of the boundary buses
`define PPS_LANES        8
`define PPS_CMD_IN_W     26
`define PPS_CMD_OUT_W    17
`define PPS_LANE_RX_W    84
`define PPS_LANE_TX_W    70
`define PPS_RX_USED_W    39
`define PPS_TX_USED_W    42

// outbound common command bus field positions
`define PPS_CO_PCLK      0
`define PPS_CO_RATE_LSB  1
`define PPS_CO_RATE_MSB  2
`define PPS_CO_RXDET     3
`define PPS_CO_MARG_LSB  4
`define PPS_CO_MARG_MSB  6
`define PPS_CO_SWING     7
`define PPS_CO_TXRST     8
`define PPS_CO_DEEMPH    9
`define PPS_CO_DEP_LSB   10
`define PPS_CO_DEP_MSB   16

// per-lane transmit bus field positions beyond the shared layout
`define PPS_TX_POL       39
`define PPS_TX_PWR_LSB   40
`define PPS_TX_PWR_MSB   41

// link rate encodings
`define PPS_RATE_GEN1    2'h0
`define PPS_RATE_GEN2    2'h1
`define PPS_RATE_GEN3    2'h2

// strap capture: cycles after reset release before the option is latched
`define PPS_STRAP_WAIT   2'h2

// nominal pipe clock frequencies in MHz, carried by the link clock input
`define PPS_PCLK_GEN1_MHZ 125
`define PPS_PCLK_GEN23_MHZ 250

`endif

/* File: core/pps_lane_packer.sv */
`timescale 1ns/1ps
`include "pps_consts.svh"

module pps_lane_packer (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        upd,
  input  wire logic                        en,
  input  wire pps_pkg::pps_tx_lane_t       core_tx,
  input  wire logic [`PPS_LANE_RX_W-1:0]   rx_bus,
  output logic      [`PPS_LANE_TX_W-1:0]   tx_bus_ff,
  output pps_pkg::pps_rx_lane_t            core_rx_ff
);

  logic [`PPS_LANE_TX_W-1:0] nxt_tx_bus;

  // deprecated upper bits stay low; boundary is quiet while disabled
  always_comb begin
    nxt_tx_bus = '0;
    if (en) begin
      nxt_tx_bus[`PPS_TX_USED_W-1:0] = core_tx;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_bus_ff <= '0;
    end else if (upd) begin
      tx_bus_ff <= nxt_tx_bus;
    end
  end

  // only the low field set is taken; bits above are left undriven by
  // many partners and must never reach the core
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_rx_ff <= '0;
    end else if (upd && en) begin
      core_rx_ff <= rx_bus[`PPS_RX_USED_W-1:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_RX_LOW_ONLY: assert property (
    upd && en |=> core_rx_ff == $past(rx_bus[`PPS_RX_USED_W-1:0]))
    else $error("receive fields not taken from low bits");

  AST_TX_LANE_CTRL: assert property (
    upd && en |=> tx_bus_ff[`PPS_TX_PWR_MSB:`PPS_TX_POL] ==
                  $past({core_tx.lane_power_state,
                         core_tx.lane_polarity_invert}))
    else $error("polarity or power state misplaced");

endmodule

/* File: core/pps_pkg.sv */
`include "pps_consts.svh"

package pps_pkg;

  typedef enum logic [1:0] {
    PPS_GEN1,
    PPS_GEN2,
    PPS_GEN3
  } pps_rate_t;

  // core-side outbound common command set
  typedef struct packed {
    logic       deemphasis_sel;
    logic       transmit_reset_flag;
    logic       transmit_swing_sel;
    logic [2:0] transmit_margin_field;
    logic       receiver_detect_req;
    pps_rate_t  link_rate_field;
  } pps_cmd_t;

  // one lane of received symbols, packed in boundary bit order
  typedef struct packed {
    logic [1:0]  lane_rx_block_header;
    logic        lane_rx_block_start;
    logic        lane_rx_valid_flag;
    logic        lane_rx_idle_flag;
    logic [1:0]  lane_rx_control_char_flags;
    logic [31:0] lane_rx_payload;
  } pps_rx_lane_t;

  // one lane of transmit symbols, same low layout plus lane controls
  typedef struct packed {
    logic [1:0]  lane_power_state;
    logic        lane_polarity_invert;
    logic [1:0]  block_header;
    logic        block_start;
    logic        valid_flag;
    logic        idle_flag;
    logic [1:0]  control_char_flags;
    logic [31:0] lane_tx_payload;
  } pps_tx_lane_t;

endpackage

/* File: core/pps_top.sv */
`timescale 1ns/1ps
`include "pps_consts.svh"

module pps_top (
  input  wire logic                                      clk,
  input  wire logic                                      rst_n,
  input  wire logic                                      link_pclk,
  input  wire logic                                      ext_pipe_en,
  input  wire pps_pkg::pps_cmd_t                         core_cmd,
  input  wire logic [`PPS_CMD_IN_W-1:0]                  common_cmd_in,
  input  wire pps_pkg::pps_tx_lane_t [`PPS_LANES-1:0]    core_tx,
  input  wire logic [`PPS_LANES-1:0][`PPS_LANE_RX_W-1:0] lane_rx_bus,
  output logic      [`PPS_CMD_OUT_W-1:0]                 common_cmd_out_ff,
  output logic      [`PPS_LANES-1:0][`PPS_LANE_TX_W-1:0] lane_tx_bus_ff,
  output pps_pkg::pps_rx_lane_t [`PPS_LANES-1:0]         core_rx_ff
);

  // link clock synchroniser; s3 is only the edge-detect history of s2
  logic pclk_s1_ff;
  logic pclk_s2_ff;
  logic pclk_s3_ff;
  logic pclk_rise;

  // option strap synchroniser and latch
  logic       strap_s1_ff;
  logic       strap_s2_ff;
  logic [1:0] strap_cnt_ff;
  logic       strap_done_ff;
  logic       en_ff;

  logic [`PPS_CMD_OUT_W-1:0] nxt_cmd_out;
  logic [1:0]                rate_code;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pclk_s1_ff <= 1'b0;
      pclk_s2_ff <= 1'b0;
      pclk_s3_ff <= 1'b0;
    end else begin
      pclk_s1_ff <= link_pclk;
      pclk_s2_ff <= pclk_s1_ff;
      pclk_s3_ff <= pclk_s2_ff;
    end
  end

  assign pclk_rise = pclk_s2_ff & ~pclk_s3_ff;

  // the option is a setup-time choice: latched once after reset release so
  // a later wiggle on the pin cannot tear the buses up mid-simulation
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_s1_ff <= 1'b0;
      strap_s2_ff <= 1'b0;
    end else begin
      strap_s1_ff <= ext_pipe_en;
      strap_s2_ff <= strap_s1_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_ff  <= 2'h0;
      strap_done_ff <= 1'b0;
      en_ff         <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == `PPS_STRAP_WAIT) begin
        strap_done_ff <= 1'b1;
        en_ff         <= strap_s2_ff;
      end
    end
  end

  always_comb begin
    case (core_cmd.link_rate_field)
      pps_pkg::PPS_GEN1: rate_code = `PPS_RATE_GEN1;
      pps_pkg::PPS_GEN2: rate_code = `PPS_RATE_GEN2;
      pps_pkg::PPS_GEN3: rate_code = `PPS_RATE_GEN3;
      default:           rate_code = `PPS_RATE_GEN1;
    endcase
  end

  // common_cmd_in is never read: the partner may drive junk
  always_comb begin
    nxt_cmd_out = '0;
    if (en_ff) begin
      nxt_cmd_out[`PPS_CO_RATE_MSB:`PPS_CO_RATE_LSB] = rate_code;
      nxt_cmd_out[`PPS_CO_RXDET] = core_cmd.receiver_detect_req;
      nxt_cmd_out[`PPS_CO_MARG_MSB:`PPS_CO_MARG_LSB] =
        core_cmd.transmit_margin_field;
      nxt_cmd_out[`PPS_CO_SWING]  = core_cmd.transmit_swing_sel;
      nxt_cmd_out[`PPS_CO_TXRST]  = core_cmd.transmit_reset_flag;
      nxt_cmd_out[`PPS_CO_DEEMPH] = core_cmd.deemphasis_sel;
    end
  end

  // clock bit follows the sampled link clock every cycle while en_ff is set, so its frequency
  // is the link clock's own; the fields only move on its rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      common_cmd_out_ff <= '0;
    end else begin
      common_cmd_out_ff[`PPS_CO_PCLK] <= en_ff & pclk_s2_ff;
      if (pclk_rise) begin
        common_cmd_out_ff[`PPS_CMD_OUT_W-1:`PPS_CO_RATE_LSB] <=
          nxt_cmd_out[`PPS_CMD_OUT_W-1:`PPS_CO_RATE_LSB];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `PPS_LANES; gi = gi + 1) begin : g_lane
      pps_lane_packer u_lane (
        .clk        (clk),
        .rst_n      (rst_n),
        .upd        (pclk_rise),
        .en         (en_ff),
        .core_tx    (core_tx[gi]),
        .rx_bus     (lane_rx_bus[gi]),
        .tx_bus_ff  (lane_tx_bus_ff[gi]),
        .core_rx_ff (core_rx_ff[gi])
      );

      // every lane is watched, not only lane 0; these carry their own clock
      // because the module default clocking is declared further down
      AST_LANE_TX: assert property (
        @(posedge clk) disable iff (!rst_n)
        pclk_rise && en_ff |=>
          lane_tx_bus_ff[gi][`PPS_TX_USED_W-1:0] == $past(core_tx[gi]) &&
          lane_tx_bus_ff[gi][`PPS_LANE_TX_W-1:`PPS_TX_USED_W] == '0)
        else $error("lane transmit bus fields misplaced");

      AST_LANE_RX: assert property (
        @(posedge clk) disable iff (!rst_n)
        pclk_rise && en_ff |=>
          core_rx_ff[gi] == $past(lane_rx_bus[gi][`PPS_RX_USED_W-1:0]))
        else $error("lane receive fields misplaced");
    end
  endgenerate

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_upd_on;
    pclk_rise && en_ff;
  endsequence

  sequence s_quiet_gap;
    !pclk_rise;
  endsequence

  AST_LANE0_EXPOSED: assert property (
    s_upd_on |=> lane_tx_bus_ff[0][`PPS_TX_USED_W-1:0] == $past(core_tx[0]))
    else $error("lane 0 transmit bus does not carry core fields");

  AST_DISABLED_QUIET: assert property (
    strap_done_ff && !en_ff |=> common_cmd_out_ff == '0 &&
                                lane_tx_bus_ff == '0)
    else $error("boundary buses active while option is off");

  AST_PCLK_FOLLOWS: assert property (
    en_ff && $rose(pclk_s2_ff) |=> $rose(common_cmd_out_ff[`PPS_CO_PCLK]))
    else $error("pipe clock bit did not follow link clock");

  AST_RATE_GEN2: assert property (
    s_upd_on ##0 core_cmd.link_rate_field == pps_pkg::PPS_GEN2 |=>
      common_cmd_out_ff[`PPS_CO_RATE_MSB:`PPS_CO_RATE_LSB] == `PPS_RATE_GEN2)
    else $error("gen2 rate code wrong");

  AST_RATE_GEN3: assert property (
    s_upd_on ##0 core_cmd.link_rate_field == pps_pkg::PPS_GEN3 |=>
      common_cmd_out_ff[`PPS_CO_RATE_MSB:`PPS_CO_RATE_LSB] == `PPS_RATE_GEN3)
    else $error("gen3 rate code wrong");

  AST_MARGIN_DEEMPH: assert property (
    s_upd_on |=>
      common_cmd_out_ff[`PPS_CO_MARG_MSB:`PPS_CO_MARG_LSB] ==
        $past(core_cmd.transmit_margin_field) &&
      common_cmd_out_ff[`PPS_CO_DEEMPH] == $past(core_cmd.deemphasis_sel) &&
      common_cmd_out_ff[`PPS_CO_DEP_MSB:`PPS_CO_DEP_LSB] == '0)
    else $error("common command fields misplaced");

  AST_INBOUND_IGNORED: assert property (
    $changed(common_cmd_in) ##0 s_quiet_gap |=>
      $stable(common_cmd_out_ff[`PPS_CMD_OUT_W-1:`PPS_CO_RATE_LSB]))
    else $error("inbound command bits disturbed outbound bus");

  AST_HOLD_BETWEEN_EDGES: assert property (
    s_quiet_gap [*2] |=> $stable(lane_tx_bus_ff) && $stable(core_rx_ff))
    else $error("lane buses moved without a pipe clock edge");

  AST_RATE_GEN1: assert property (
    s_upd_on ##0 core_cmd.link_rate_field == pps_pkg::PPS_GEN1 |=>
      common_cmd_out_ff[`PPS_CO_RATE_MSB:`PPS_CO_RATE_LSB] == `PPS_RATE_GEN1)
    else $error("gen1 rate code wrong");

  AST_TX_CONTROLS: assert property (
    s_upd_on |=>
      common_cmd_out_ff[`PPS_CO_RXDET] ==
        $past(core_cmd.receiver_detect_req) &&
      common_cmd_out_ff[`PPS_CO_SWING] ==
        $past(core_cmd.transmit_swing_sel) &&
      common_cmd_out_ff[`PPS_CO_TXRST] ==
        $past(core_cmd.transmit_reset_flag))
    else $error("detect, swing or reset bit misplaced");

  // the option is taken once per reset; later pin moves must not show
  AST_STRAP_ONCE: assert property (
    strap_done_ff |=> $stable(en_ff) && strap_done_ff)
    else $error("external option changed after it was latched");

  AST_PCLK_FALLS: assert property (
    $fell(pclk_s2_ff) |=> !common_cmd_out_ff[`PPS_CO_PCLK])
    else $error("pipe clock bit stayed high after link clock fell");

endmodule

/* File: dv/pps_link_partner.sv */
`timescale 1ns/1ps
`include "pps_consts.svh"

module pps_link_partner (
  input  wire logic                                      link_pclk,
  output logic      [`PPS_CMD_IN_W-1:0]                  common_cmd_in,
  output logic      [`PPS_LANES-1:0][`PPS_LANE_RX_W-1:0] lane_rx_bus
);
  // the deprecated transmit bits are never read on this side
  initial begin
    common_cmd_in = '0;
    lane_rx_bus   = '0;
  end

  // launch on the falling link clock so fields stand across the rise
  always @(negedge link_pclk) begin
    logic [95:0] r;
    r = {$urandom, $urandom, $urandom};
    common_cmd_in <= r[`PPS_CMD_IN_W-1:0];
    for (int l = 0; l < `PPS_LANES; l++) begin
      r = {$urandom, $urandom, $urandom};
      // unused upper bits carry noise, not a stale copy
      lane_rx_bus[l] <= r[`PPS_LANE_RX_W-1:0];
    end
  end
endmodule

/* File: dv/pps_top_test.sv */
`timescale 1ns/1ps
`include "pps_consts.svh"

module pps_top_test;
  logic                                      clk;
  logic                                      rst_n;
  logic                                      link_pclk;
  logic                                      en;
  logic                                      en_l;
  logic                                      chk_on;
  pps_pkg::pps_cmd_t                         cmd;
  logic      [`PPS_CMD_IN_W-1:0]             cin;
  pps_pkg::pps_tx_lane_t [`PPS_LANES-1:0]    ctx;
  logic      [`PPS_LANES-1:0][`PPS_LANE_RX_W-1:0] rx;
  logic      [`PPS_CMD_OUT_W-1:0]            cout;
  logic      [`PPS_LANES-1:0][`PPS_LANE_TX_W-1:0] txb;
  pps_pkg::pps_rx_lane_t [`PPS_LANES-1:0]    crx;
  logic      [1:0]                           rate_v;
  logic      [6:0]                           cr;
  logic      [`PPS_LANES-1:0][41:0]          tv;
  logic      [16:0]                          q_cmd[$];
  logic      [7:0][69:0]                     q_tx[$];
  logic      [7:0][38:0]                     q_rx[$];
  int                                        fails;
  int                                        check_count;
  int                                        cyc;

  pps_top pps_top_inst (.clk(clk), .rst_n(rst_n), .link_pclk(link_pclk),
    .ext_pipe_en(en), .core_cmd(cmd), .common_cmd_in(cin), .core_tx(ctx),
    .lane_rx_bus(rx), .common_cmd_out_ff(cout), .lane_tx_bus_ff(txb),
    .core_rx_ff(crx));

  pps_link_partner pps_link_partner_inst (.link_pclk(link_pclk),
    .common_cmd_in(cin), .lane_rx_bus(rx));

  always #4 clk = ~clk;

  // offset keeps link edges clear of every system clock edge
  initial begin
    link_pclk = 1'b0;
    #3;
    forever #32 link_pclk = ~link_pclk;
  end

  task automatic chk(input logic ok, input string what);
    check_count++;
    if (!ok) begin
      fails++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask

  task automatic close_out();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(negedge link_pclk) begin
    logic [63:0] r;
    if (chk_on) chk(cout[0] === en_l, "clock bit");
    // inputs move on a falling system clock edge, clear of all sampling
    @(negedge clk);
    rate_v = (rate_v == 2'h2) ? 2'h0 : rate_v + 2'h1;
    r = {$urandom, $urandom};
    cr = r[6:0];
    cmd.link_rate_field = pps_pkg::pps_rate_t'(rate_v);
    cmd.receiver_detect_req = cr[0];
    cmd.transmit_margin_field = cr[3:1];
    cmd.transmit_swing_sel = cr[4];
    cmd.transmit_reset_flag = cr[5];
    cmd.deemphasis_sel = cr[6];
    for (int l = 0; l < `PPS_LANES; l++) begin
      r = {$urandom, $urandom};
      tv[l] = r[41:0];
      ctx[l].lane_tx_payload = tv[l][31:0];
      ctx[l].control_char_flags = tv[l][33:32];
      ctx[l].idle_flag = tv[l][34];
      ctx[l].valid_flag = tv[l][35];
      ctx[l].block_start = tv[l][36];
      ctx[l].block_header = tv[l][38:37];
      ctx[l].lane_polarity_invert = tv[l][39];
      ctx[l].lane_power_state = tv[l][41:40];
    end
  end

  // each rise shows what the previous rise captured
  always @(posedge link_pclk) begin
    logic [16:0]      ec;
    logic [7:0][69:0] et;
    logic [7:0][38:0] er;
    if (!chk_on) begin
      q_cmd.delete();
      q_tx.delete();
      q_rx.delete();
    end else begin
      chk(cout[0] === 1'b0, "clock bit low");
      if (q_cmd.size() > 0) begin
        chk(cout === q_cmd.pop_front(), "common out");
        chk(txb === q_tx.pop_front(), "lane tx");
        chk(crx === q_rx.pop_front(), "lane rx");
      end
      ec = '0;
      et = '0;
      er = '0;
      if (en_l === 1'b1) begin
        ec = {7'h00, cr[6], cr[5], cr[4], cr[3:1], cr[0], rate_v, 1'b0};
        for (int l = 0; l < `PPS_LANES; l++) begin
          et[l][41:0] = tv[l];
          er[l] = rx[l][38:0];
        end
      end
      q_cmd.push_back(ec);
      q_tx.push_back(et);
      q_rx.push_back(er);
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      chk(1'b0, "timeout");
      close_out();
    end
  end

  task automatic reset_run(input logic en_v, input int n, input string nm);
    chk_on = 1'b0;
    @(negedge clk);
    rst_n = 1'b0;
    en = en_v;
    en_l = en_v;
    repeat (10) @(negedge clk);
    chk(cout === '0 && txb === '0 && crx === '0, "reset outputs");
    rst_n = 1'b1;
    repeat (2) @(negedge link_pclk);
    #1 chk_on = 1'b1;
    repeat (n) @(posedge link_pclk);
    $display("test %s done: checks %0d fails %0d", nm, check_count, fails);
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    en = 1'b1;
    en_l = 1'b1;
    chk_on = 1'b0;
    cmd = '0;
    ctx = '0;
    tv = '0;
    cr = '0;
    rate_v = 2'h0;
    cyc = 0;
    fails = 0;
    check_count = 0;
    void'($urandom(32'h4B56C760));
    reset_run(1'b1, 40, "enabled");
    // option is a setup choice; a late change must not matter
    @(negedge clk);
    en = 1'b0;
    repeat (20) @(posedge link_pclk);
    $display("test latched option done: fails %0d", fails);
    reset_run(1'b0, 30, "disabled");
    reset_run(1'b1, 20, "reenabled");
    close_out();
  end
endmodule
